// >>> shared/bhr_pkg.sv
package bhr_pkg;

    // ----------------------------------------------------------------
    // Widths and timing
    // ----------------------------------------------------------------
    localparam int ADDR_W_DEF = 20;
    localparam int DATA_W_DEF = 16;
    localparam int CNT_W_DEF = 9;
    // Core clock rate and the bus clock divider that sets one bus clock period.
    localparam int CORE_CLK_HZ = 40_000_000;
    localparam int BUS_DIV = 2;
    // Refresh strobe width in tenths of a bus clock period (1.5 periods).
    localparam int RFSH_PULSE_TENTHS = 15;
    localparam int RFSH_LOW_CYCLES_I = (RFSH_PULSE_TENTHS * BUS_DIV + 9) / 10;
    localparam logic [1:0] RFSH_LOW_CYCLES = RFSH_LOW_CYCLES_I[1:0];
    // Cycles after reset release until the strap has crossed the synchroniser.
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // ----------------------------------------------------------------
    // Bus status codes and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0] STAT_PASSIVE = 3'h7;
    localparam logic [2:0] STAT_MEM_RD = 3'h5;
    localparam logic [2:0] STAT_MEM_WR = 3'h6;
    localparam logic STRAP_RESET_VAL = 1'b1;

    // Bus sequencer states.
    typedef enum logic [2:0] {
        BHR_IDLE,
        BHR_T1,
        BHR_T2,
        BHR_T3,
        BHR_T4,
        BHR_HOLD_OFF,
        BHR_HOLD,
        BHR_RECLAIM
    } bhr_state_e;

endpackage

// >>> rtl/bhr_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for pins that arrive from outside the core clock.
module bhr_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta;

    // ----------------------------------------------------------------
    // Synchroniser flops
    // ----------------------------------------------------------------
    // The first stage is read only by the second stage.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// >>> rtl/bhr_top.sv
`timescale 1ns/100ps
// Bus hold arbitration, refresh strobe and address-drive control.
module bhr_top
    import bhr_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF,
    parameter int CNT_W = CNT_W_DEF
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic cyc_req,
    input wire logic [ADDR_W-1:0] cyc_addr,
    input wire logic [DATA_W-1:0] cyc_wdata,
    input wire logic cyc_write,
    input wire logic cyc_byte_hi,
    input wire logic cyc_byte_lo,
    input wire logic cyc_lcs,
    input wire logic cyc_ucs,
    input wire logic [3:0] cyc_mcs,
    input wire logic [3:0] cyc_pcs,
    output logic cyc_done,
    output logic [DATA_W-1:0] cyc_rdata,
    input wire logic low_da_bit,
    input wire logic upper_da_bit,
    input wire logic mcs0_whole_range,
    input wire logic mcs3_byte_wide,
    input wire logic refresh_enable,
    input wire logic [CNT_W-1:0] refresh_period,
    input wire logic pio25_out,
    input wire logic pio25_oe,
    output logic [CNT_W-1:0] refresh_count,
    output logic address_strap_high,
    input wire logic hold,
    output logic hlda,
    output logic clkouta,
    input wire logic [DATA_W-1:0] muxed_addr_data_bus_in,
    output logic [DATA_W-1:0] muxed_addr_data_bus_out,
    output logic muxed_addr_data_bus_oe,
    output logic [ADDR_W-1:0] address_pins,
    output logic address_pins_oe,
    input wire logic upper_byte_en_n_in,
    output logic upper_byte_en_n_out,
    output logic ctl_oe,
    output logic rd_n,
    output logic wr_n,
    output logic den_n,
    output logic data_direction,
    output logic [2:0] bus_status_code,
    output logic status_bit_six,
    output logic whb_n,
    output logic wlb_n,
    output logic lcs_n,
    output logic ucs_n,
    output logic [2:0] mid_memory_select_n,
    output logic mid_memory_select3_n,
    output logic mid_memory_select3_oe,
    output logic [3:0] peripheral_selects_n
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // The refresh marking and byte lanes assume a 16-bit muxed bus.
    if (DATA_W != 16 || ADDR_W < DATA_W || CNT_W < 1) begin : g_bad_params
        $error("bhr_top: unsupported width parameters");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] pin_sync;
    logic [DATA_W-1:0] bus_sync;
    logic hold_s;
    logic aden_s;

    // Hold may come from an unrelated clock, so it is synchronised first.
    bhr_sync #(.W(2)) u_ctl_sync (
        .core_clk(core_clk),
        .reset(reset),
        .d({hold, upper_byte_en_n_in}),
        .q(pin_sync)
    );
    assign hold_s = pin_sync[1];
    assign aden_s = pin_sync[0];

    bhr_sync #(.W(DATA_W)) u_bus_sync (
        .core_clk(core_clk),
        .reset(reset),
        .d(muxed_addr_data_bus_in),
        .q(bus_sync)
    );

    // ----------------------------------------------------------------
    // Bus clock divider
    // ----------------------------------------------------------------
    logic clk_div;
    logic next_clk_div;
    logic bus_ce;

    // Left out of reset so the clock output keeps toggling through it; an unknown
    // start value falls into the else branch and settles on the first edge.
    always_comb begin
        if (clk_div) begin
            next_clk_div = 1'b0;
        end else begin
            next_clk_div = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        clk_div <= next_clk_div;
        clkouta <= next_clk_div;
    end

    assign bus_ce = clk_div;

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    logic [1:0] strap_cnt;
    logic [1:0] next_strap_cnt;
    logic next_strap_high;

    // The strap is taken once the synchroniser has seen the pin after release.
    always_comb begin
        next_strap_cnt = strap_cnt;
        next_strap_high = address_strap_high;
        if (strap_cnt != STRAP_SETTLE) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt + 2'h1 == STRAP_SETTLE) begin
                next_strap_high = aden_s;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            strap_cnt <= '0;
            address_strap_high <= STRAP_RESET_VAL;
        end else begin
            strap_cnt <= next_strap_cnt;
            address_strap_high <= next_strap_high;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer, refresh counter and cycle context
    // ----------------------------------------------------------------
    bhr_state_e state;
    bhr_state_e next_state;
    logic rfsh_pend, next_rfsh_pend;
    logic [CNT_W-1:0] next_refresh_count;
    logic [ADDR_W-1:0] rfsh_addr, next_rfsh_addr;
    logic [1:0] rfsh_left, next_rfsh_left;
    logic cur_rfsh, next_cur_rfsh;
    logic [ADDR_W-1:0] cur_addr, next_cur_addr;
    logic [DATA_W-1:0] cur_wdata, next_cur_wdata;
    logic cur_write, next_cur_write;
    logic [1:0] cur_lanes, next_cur_lanes;
    logic [9:0] cur_cs, next_cur_cs;
    logic next_cyc_done;
    logic [DATA_W-1:0] next_cyc_rdata;
    logic take_rfsh;
    logic rfsh_set;

    always_comb begin
        next_state = state;
        next_cur_rfsh = cur_rfsh;
        next_cur_addr = cur_addr;
        next_cur_wdata = cur_wdata;
        next_cur_write = cur_write;
        next_cur_lanes = cur_lanes;
        next_cur_cs = cur_cs;
        next_cyc_done = 1'b0;
        next_cyc_rdata = cyc_rdata;
        take_rfsh = 1'b0;
        case (state)
            BHR_IDLE: begin
                if (bus_ce) begin
                    // Refresh goes first so a hold grant is not withdrawn at once.
                    if (rfsh_pend) begin
                        take_rfsh = 1'b1;
                        next_state = BHR_T1;
                        next_cur_rfsh = 1'b1;
                        next_cur_addr = rfsh_addr;
                        next_cur_write = 1'b0;
                        next_cur_lanes = 2'h0;
                        next_cur_cs = '0;
                    end else if (hold_s) begin
                        next_state = BHR_HOLD_OFF;
                    end else if (cyc_req) begin
                        next_state = BHR_T1;
                        next_cur_rfsh = 1'b0;
                        next_cur_addr = cyc_addr;
                        next_cur_wdata = cyc_wdata;
                        next_cur_write = cyc_write;
                        // An 8-bit fourth middle region only uses the low lane.
                        next_cur_lanes = {cyc_byte_hi & ~(cyc_mcs[3] & mcs3_byte_wide),
                                          cyc_byte_lo};
                        next_cur_cs = {cyc_lcs, cyc_ucs, cyc_mcs, cyc_pcs};
                    end
                end
            end
            BHR_T1: if (bus_ce) next_state = BHR_T2;
            BHR_T2: if (bus_ce) next_state = BHR_T3;
            BHR_T3: if (bus_ce) next_state = BHR_T4;
            BHR_T4: begin
                if (bus_ce) begin
                    next_state = BHR_IDLE;
                    next_cyc_done = ~cur_rfsh;
                    next_cyc_rdata = bus_sync;
                end
            end
            BHR_HOLD_OFF: if (bus_ce) next_state = BHR_HOLD;
            BHR_HOLD: begin
                if (bus_ce) begin
                    if (!hold_s) begin
                        next_state = BHR_IDLE;
                    end else if (rfsh_pend) begin
                        next_state = BHR_RECLAIM;
                    end
                end
            end
            // Master still owns the bus until it drops hold.
            BHR_RECLAIM: if (bus_ce && !hold_s) next_state = BHR_IDLE;
            default: next_state = BHR_IDLE;
        endcase
    end

    // Refresh counter: clearing enable clears the count and any request,
    // while the refresh address is kept.
    always_comb begin
        next_refresh_count = refresh_count;
        rfsh_set = 1'b0;
        if (!refresh_enable) begin
            next_refresh_count = '0;
        end else if (bus_ce) begin
            if (refresh_count <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                next_refresh_count = refresh_period;
                rfsh_set = (refresh_count != '0);
            end else begin
                next_refresh_count = refresh_count - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
        // A new request in the cycle one is taken wins over the clear.
        next_rfsh_pend = refresh_enable & ((rfsh_pend & ~take_rfsh) | rfsh_set);
        next_rfsh_addr = take_rfsh ? rfsh_addr + {{(ADDR_W-1){1'b0}}, 1'b1} : rfsh_addr;
        if (take_rfsh && refresh_enable) begin
            next_rfsh_left = RFSH_LOW_CYCLES;
        end else if (rfsh_left != 2'h0) begin
            next_rfsh_left = rfsh_left - 2'h1;
        end else begin
            next_rfsh_left = 2'h0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state <= BHR_IDLE;
            rfsh_pend <= 1'b0;
            refresh_count <= '0;
            rfsh_addr <= '0;
            rfsh_left <= 2'h0;
            cur_rfsh <= 1'b0;
            cur_addr <= '0;
            cur_wdata <= '0;
            cur_write <= 1'b0;
            cur_lanes <= 2'h0;
            cur_cs <= '0;
            cyc_done <= 1'b0;
            cyc_rdata <= '0;
        end else begin
            state <= next_state;
            rfsh_pend <= next_rfsh_pend;
            refresh_count <= next_refresh_count;
            rfsh_addr <= next_rfsh_addr;
            rfsh_left <= next_rfsh_left;
            cur_rfsh <= next_cur_rfsh;
            cur_addr <= next_cur_addr;
            cur_wdata <= next_cur_wdata;
            cur_write <= next_cur_write;
            cur_lanes <= next_cur_lanes;
            cur_cs <= next_cur_cs;
            cyc_done <= next_cyc_done;
            cyc_rdata <= next_cyc_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    logic n_hlda, n_mux_oe, n_addr_oe, n_ubn, n_ctl_oe, n_rd_n, n_wr_n, n_den_n, n_dt;
    logic n_s6, n_whb_n, n_wlb_n, n_lcs_n, n_ucs_n, n_m3_n, n_m3_oe;
    logic [DATA_W-1:0] n_mux;
    logic [2:0] n_stat, n_mcs_n;
    logic [3:0] n_pcs_n;
    logic addr_drive, sel_on, in_hold;

    // Computed from the next state so the pins line up with the state flops.
    always_comb begin
        in_hold = (next_state == BHR_HOLD_OFF) || (next_state == BHR_HOLD) ||
                  (next_state == BHR_RECLAIM);
        sel_on = (next_state == BHR_T1) || (next_state == BHR_T2) || (next_state == BHR_T3);
        // Strap low forces the address out; strap high hands it to the DA bits.
        addr_drive = next_cur_rfsh || !address_strap_high ||
                     !((next_cur_cs[9] && low_da_bit) ||
                       (next_cur_cs[8] && upper_da_bit));
        n_hlda = (next_state == BHR_HOLD);
        n_addr_oe = !in_hold;
        n_ctl_oe = !in_hold;
        n_mux_oe = 1'b0;
        n_mux = '0;
        n_ubn = 1'b1;
        n_rd_n = 1'b1;
        n_wr_n = 1'b1;
        n_den_n = 1'b1;
        n_dt = 1'b1;
        n_stat = STAT_PASSIVE;
        n_s6 = 1'b0;
        n_whb_n = 1'b1;
        n_wlb_n = 1'b1;
        case (next_state)
            BHR_T1: begin
                n_mux_oe = addr_drive;
                // Refresh marks itself with bit 0 high, which the address pins need not.
                n_mux = next_cur_rfsh ? {next_cur_addr[DATA_W-1:1], 1'b1} :
                        next_cur_addr[DATA_W-1:0];
                n_ubn = next_cur_rfsh ? 1'b1 : ~next_cur_lanes[1];
                n_stat = next_cur_write ? STAT_MEM_WR : STAT_MEM_RD;
            end
            BHR_T2, BHR_T3: begin
                n_mux_oe = next_cur_write;
                n_mux = next_cur_wdata;
                n_ubn = ~next_cur_lanes[1];
                n_rd_n = next_cur_write | next_cur_rfsh;
                n_wr_n = ~next_cur_write;
                n_den_n = next_cur_rfsh;
                n_dt = next_cur_write;
                n_stat = next_cur_write ? STAT_MEM_WR : STAT_MEM_RD;
                n_whb_n = ~(next_cur_write & next_cur_lanes[1]);
                n_wlb_n = ~(next_cur_write & next_cur_lanes[0]);
            end
            default: n_mux_oe = 1'b0;
        endcase
        // Chip selects are high whenever the bus is given away.
        n_lcs_n = ~(sel_on & next_cur_cs[9]);
        n_ucs_n = ~(sel_on & next_cur_cs[8]);
        n_mcs_n = ~({3{sel_on}} & next_cur_cs[6:4]);
        n_pcs_n = ~({4{sel_on}} & next_cur_cs[3:0]);
        // Select three: strobe in refresh mode, high in hold, otherwise general I/O in whole-range mode.
        if (refresh_enable) begin
            n_m3_n = (next_rfsh_left == 2'h0);
            n_m3_oe = 1'b1;
        end else if (in_hold) begin
            n_m3_n = 1'b1;
            n_m3_oe = 1'b1;
        end else if (mcs0_whole_range) begin
            n_m3_n = pio25_out;
            n_m3_oe = pio25_oe;
        end else begin
            n_m3_n = ~(sel_on & next_cur_cs[7]);
            n_m3_oe = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hlda <= 1'b0;
            muxed_addr_data_bus_out <= '0;
            muxed_addr_data_bus_oe <= 1'b0;
            address_pins <= '0;
            address_pins_oe <= 1'b0;
            upper_byte_en_n_out <= 1'b1;
            ctl_oe <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            den_n <= 1'b1;
            data_direction <= 1'b1;
            bus_status_code <= STAT_PASSIVE;
            status_bit_six <= 1'b0;
            whb_n <= 1'b1;
            wlb_n <= 1'b1;
            lcs_n <= 1'b1;
            ucs_n <= 1'b1;
            mid_memory_select_n <= 3'h7;
            mid_memory_select3_n <= 1'b1;
            mid_memory_select3_oe <= 1'b0;
            peripheral_selects_n <= 4'hf;
        end else begin
            hlda <= n_hlda;
            muxed_addr_data_bus_out <= n_mux;
            muxed_addr_data_bus_oe <= n_mux_oe;
            address_pins <= next_cur_addr;
            address_pins_oe <= n_addr_oe;
            upper_byte_en_n_out <= n_ubn;
            ctl_oe <= n_ctl_oe;
            rd_n <= n_rd_n;
            wr_n <= n_wr_n;
            den_n <= n_den_n;
            data_direction <= n_dt;
            bus_status_code <= n_stat;
            status_bit_six <= n_s6;
            whb_n <= n_whb_n;
            wlb_n <= n_wlb_n;
            lcs_n <= n_lcs_n;
            ucs_n <= n_ucs_n;
            mid_memory_select_n <= n_mcs_n;
            mid_memory_select3_n <= n_m3_n;
            mid_memory_select3_oe <= n_m3_oe;
            peripheral_selects_n <= n_pcs_n;
        end
    end

endmodule

// >>> sim/bhr_checker.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Hold, refresh strobe and pin-drive relations at the top ports.
// ----------------------------------------------------------------
module bhr_checker #(
    parameter int DATA_W = 16
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic hold,
    input wire logic hlda,
    input wire logic clkouta,
    input wire logic refresh_enable,
    input wire logic mcs0_whole_range,
    input wire logic [DATA_W-1:0] muxed_addr_data_bus_out,
    input wire logic muxed_addr_data_bus_oe,
    input wire logic address_pins_oe,
    input wire logic ctl_oe,
    input wire logic upper_byte_en_n_out,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic lcs_n,
    input wire logic ucs_n,
    input wire logic [2:0] mid_memory_select_n,
    input wire logic mid_memory_select3_n,
    input wire logic mid_memory_select3_oe,
    input wire logic [3:0] peripheral_selects_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    // Select three only counts as the strobe while refresh mode owns the pin.
    bus_float_a: assert property (hlda |-> !muxed_addr_data_bus_oe && !address_pins_oe)
        else $error("bus outputs driven while hold is granted");
    ctl_float_a: assert property (hlda |-> !ctl_oe)
        else $error("control outputs driven while hold is granted");
    sel_high_a: assert property (hlda |-> lcs_n && ucs_n
        && &mid_memory_select_n && &peripheral_selects_n) else $error("select low in hold");
    mid3_high_a: assert property (hlda && !refresh_enable && !mcs0_whole_range
        |-> mid_memory_select3_n && mid_memory_select3_oe) else $error("select three in hold");
    strobe_kept_a: assert property (hlda && refresh_enable |-> mid_memory_select3_oe)
        else $error("refresh strobe released in hold");
    strobe_width_a: assert property ($fell(mid_memory_select3_n) && refresh_enable
        |-> !mid_memory_select3_n [*3] ##1 mid_memory_select3_n) else $error("strobe width");
    refresh_mark_a: assert property ($fell(mid_memory_select3_n) && refresh_enable
        && muxed_addr_data_bus_oe |-> muxed_addr_data_bus_out[0] && upper_byte_en_n_out)
        else $error("refresh cycle not marked");
    no_grant_a: assert property ($fell(rd_n) || $fell(wr_n) |-> !hlda [*6])
        else $error("hold granted inside a bus cycle");
    grant_time_a: assert property ($rose(hold) && !refresh_enable |-> ##[1:24] hlda)
        else $error("hold not granted in time");
    release_a: assert property ($fell(hold) && hlda |-> ##[1:6] !hlda)
        else $error("hold acknowledge not dropped");
    clk_run_a: assert property (hlda |-> clkouta != $past(clkouta))
        else $error("bus clock stopped in hold");

    cover property ($rose(hlda));
    cover property ($fell(hlda) && hold);
    cover property ($fell(mid_memory_select3_n) && refresh_enable);
endmodule

bind bhr_top bhr_checker #(.DATA_W(DATA_W)) i_chk (.*);

// >>> sim/bhr_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// External master and memory on the far side of the bus.
// ----------------------------------------------------------------
module bhr_mem_model (
    input wire logic core_clk,
    input wire logic hold_req,
    input wire logic hlda,
    input wire logic rd_n,
    input wire logic [19:0] address_pins,
    output logic hold,
    output logic [15:0] muxed_addr_data_bus_in
);
    logic hlda_q = 1'b0;
    int gap = 16;

    initial hold = 1'b0;
    initial muxed_addr_data_bus_in = 16'h0000;

    // Read data follows the address; a released bus flips every cycle so stale data fails.
    always @(posedge core_clk) begin
        hlda_q <= hlda;
        if (!rd_n) begin
            muxed_addr_data_bus_in <= address_pins[15:0] ^ 16'h5a3c;
        end else begin
            muxed_addr_data_bus_in <= ~muxed_addr_data_bus_in;
        end
        // After a release hold stays low for a while, so a reclaiming device surely sees it.
        if (!hold_req || (hold && hlda_q && !hlda)) begin
            hold <= 1'b0;
            gap <= 16;
        end else if (gap > 0) begin
            gap <= gap - 1;
        end else if (!hlda) begin
            hold <= 1'b1;
        end
    end
endmodule

// >>> sim/bhr_top_tb.sv
`timescale 1ns/100ps
module bhr_top_tb import bhr_pkg::*; ;
    typedef struct packed {
        logic [19:0] a;
        logic [15:0] d;
        logic oe;
        logic use_oe;
        logic ub;
    } bhr_note_s;
    logic core_clk = 1'b0, reset = 1'b1, cyc_req = 1'b0, cyc_write = 1'b0, cyc_byte_hi = 1'b1;
    logic cyc_byte_lo = 1'b1, cyc_lcs = 1'b1, cyc_ucs = 1'b0, low_da_bit = 1'b0;
    logic upper_da_bit = 1'b0, mcs0_whole_range = 1'b0, mcs3_byte_wide = 1'b0;
    logic refresh_enable = 1'b0, pio25_out = 1'b0, pio25_oe = 1'b0, upper_byte_en_n_in = 1'b0;
    logic hold_req = 1'b0;
    logic [19:0] cyc_addr = 20'h00000;
    logic [15:0] cyc_wdata = 16'h0000;
    logic [3:0] cyc_mcs = 4'h0, cyc_pcs = 4'h0;
    logic [8:0] refresh_period = 9'h010;
    logic cyc_done, address_strap_high, hold, hlda, clkouta, muxed_addr_data_bus_oe, ctl_oe;
    logic address_pins_oe, upper_byte_en_n_out, rd_n, wr_n, den_n, data_direction, whb_n;
    logic wlb_n, status_bit_six, lcs_n, ucs_n, mid_memory_select3_n, mid_memory_select3_oe;
    logic [15:0] cyc_rdata, muxed_addr_data_bus_in, muxed_addr_data_bus_out;
    logic [19:0] address_pins;
    logic [8:0] refresh_count;
    logic [2:0] bus_status_code, mid_memory_select_n;
    logic [3:0] peripheral_selects_n;
    int errors = 0, samples_checked = 0, falls = 0, reclaims = 0;
    bhr_note_s q[$];
    wire [9:0] sel_n_all = {peripheral_selects_n, mid_memory_select3_n, mid_memory_select_n,
        ucs_n, lcs_n};
    wire [2:0] rfsh_mark = {muxed_addr_data_bus_oe, muxed_addr_data_bus_out[0], upper_byte_en_n_out};

    bhr_top i_dut (.*);
    bhr_mem_model i_mem (.*);

    initial forever #12.5 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A read notes its expectation first; the strap level is the bench's own, not the capture.
    task automatic rd(input logic [19:0] a, input int r, input logic l, input logic u);
        bhr_note_s n;
        logic w;
        // An 8-bit fourth middle region must keep the upper lane off.
        w = 1'($urandom);
        n = '{a, a[15:0] ^ 16'h5a3c, !upper_byte_en_n_in || (r == 0 ? !l : !u), r < 2,
            r == 5 && w};
        q.push_back(n);
        {cyc_pcs, cyc_mcs, cyc_ucs, cyc_lcs} <= 10'h001 << r;
        {low_da_bit, upper_da_bit, cyc_req, mcs3_byte_wide} <= {l, u, 1'b1, w};
        cyc_addr <= a;
        cyc_wdata <= 16'($urandom);
        {pio25_out, pio25_oe} <= 2'($urandom);
        for (int i = 0; i < 40 && cyc_done !== 1'b1; i++) @(posedge core_clk);
        chk("cycle done", 20'h00001, 20'(cyc_done));
        cyc_req <= 1'b0;
        @(posedge core_clk);
    endtask

    // Monitor: address phase at the first select edge, read data when the cycle completes.
    always @(posedge core_clk) begin
        if ($fell(mid_memory_select3_n) && !cyc_req) falls++;
        if ($fell(hlda) && hold) reclaims++;
        if ($fell(&sel_n_all) && cyc_req && q.size() > 0) begin
            chk("address", q[0].a, address_pins);
            chk("upper lane", 20'(q[0].ub), 20'(upper_byte_en_n_out));
            if (q[0].use_oe) chk("mux drive", 20'(q[0].oe), 20'(muxed_addr_data_bus_oe));
            if (q[0].use_oe && q[0].oe) begin
                chk("mux addr", 20'(q[0].a[15:0]), 20'(muxed_addr_data_bus_out));
            end
        end
        // Refresh is told apart by muxed bit 0 and the upper enable, never by the address pins.
        if ($fell(mid_memory_select3_n) && refresh_enable) begin
            chk("refresh mark", 20'h00007, 20'(rfsh_mark));
        end
        if (cyc_done === 1'b1 && q.size() > 0) begin
            chk("rdata", 20'(q[0].d), 20'(cyc_rdata));
            void'(q.pop_front());
        end
    end

    // Runs well under the limit; only a hung handshake reaches it.
    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(54029));
        for (int s = 0; s < 2; s++) begin
            upper_byte_en_n_in <= s[0];
            reset <= 1'b1;
            repeat (10) @(posedge core_clk);
            reset <= 1'b0;
            repeat (5) @(posedge core_clk);
            chk("strap", 20'(s), 20'(address_strap_high));
            for (int i = 0; i < 12; i++) begin
                rd(20'($urandom), int'($urandom % 10), 1'($urandom), 1'($urandom));
            end
        end
        hold_req <= 1'b1;
        for (int i = 0; i < 60 && hlda !== 1'b1; i++) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        chk("hold ack", 20'h00001, 20'(hlda));
        chk("bus float", 20'h00000, 20'({muxed_addr_data_bus_oe, address_pins_oe, ctl_oe}));
        chk("selects", 20'h003ff, 20'(sel_n_all));
        hold_req <= 1'b0;
        for (int i = 0; i < 20 && hlda !== 1'b0; i++) @(posedge core_clk);
        chk("hold release", 20'h00000, 20'(hlda));
        rd(20'h00402, 0, 1'b0, 1'b0);
        repeat (100) @(posedge core_clk);
        chk("idle strobe", 20'h00000, 20'(falls));
        refresh_enable <= 1'b1;
        for (int i = 0; i < 200 && falls == 0; i++) @(posedge core_clk);
        chk("strobe seen", 20'h00001, 20'(falls > 0));
        hold_req <= 1'b1;
        repeat (400) @(posedge core_clk);
        chk("reclaim", 20'h00001, 20'(reclaims > 0));
        chk("refresh in hold", 20'h00001, 20'(falls > 2));
        {hold_req, refresh_enable} <= 2'b00;
        repeat (20) @(posedge core_clk);
        tally_and_finish();
    end
endmodule
